/* File: common/fpe_pkg.sv */
/*
  Constants, command codes and types for the flash command sequencer host.
  Assumes a 25 MHz clock and a flash part in word mode on a 20-bit address bus.
*/
package fpe_pkg;
    // ========================================
    // Bus geometry
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int SECT_LSB = 12;
    localparam int POLL_BIT = 7;
    localparam int LIMIT_BIT = 5;

    // ========================================
    // Timing
    localparam int CLK_NS = 40;
    localparam int CLK_MHZ = 25;
    localparam int T_WIN_US = 50;
    localparam int WIN_CYC = T_WIN_US * CLK_MHZ;
    localparam int WIN_GUARD_CYC = 16;
    localparam int T_WP_NS = 35;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACC_NS = 90;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_RP_NS = 500;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;

    // ========================================
    // Addresses and command codes
    localparam logic [19:0] A_UNLOCK1 = 20'h00555;
    localparam logic [19:0] A_UNLOCK2 = 20'h002AA;
    localparam logic [19:0] A_QUERY = 20'h00055;
    localparam logic [19:0] A_ANY = 20'h00000;
    localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] D_UNLOCK2 = 16'h0055;
    localparam logic [15:0] D_PROG = 16'h00A0;
    localparam logic [15:0] D_BYP_ENTER = 16'h0020;
    localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] D_CHIP = 16'h0010;
    localparam logic [15:0] D_SECTOR = 16'h0030;
    localparam logic [15:0] D_SUSPEND = 16'h00B0;
    localparam logic [15:0] D_RESUME = 16'h0030;
    localparam logic [15:0] D_RESET = 16'h00F0;
    localparam logic [15:0] D_QUERY = 16'h0098;
    localparam logic [15:0] D_ID = 16'h0090;
    localparam logic [15:0] D_BYP_EXIT1 = 16'h0090;
    localparam logic [15:0] D_BYP_EXIT2 = 16'h0000;

    // ========================================
    // Types
    typedef enum logic [3:0] {
        OP_PROG = 4'h0, OP_BYP_ENTER = 4'h1, OP_BYP_PROG = 4'h2, OP_BYP_EXIT = 4'h3,
        OP_CHIP = 4'h4, OP_SECTOR = 4'h5, OP_SECT_ADD = 4'h6, OP_SUSPEND = 4'h7,
        OP_RESUME = 4'h8, OP_RESET = 4'h9, OP_QUERY = 4'hA, OP_ID = 4'hB,
        OP_READ = 4'hC, OP_WAIT = 4'hD, OP_HWRESET = 4'hE
    } fpe_op_type;

    typedef enum logic [2:0] {
        MD_READ = 3'h0, MD_ID = 3'h1, MD_QUERY = 3'h2, MD_BYPASS = 3'h3,
        MD_WINDOW = 3'h4, MD_ERASING = 3'h5, MD_SUSP = 3'h6
    } fpe_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_SEQ = 3'b001, ST_WAIT = 3'b011, ST_POLL = 3'b010,
        ST_PWAIT = 3'b110, ST_RESP = 3'b111, ST_FAIL = 3'b101, ST_HWR = 3'b100
    } fpe_state_type;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000, PH_SETUP = 3'b001, PH_PULSE = 3'b011, PH_HOLD = 3'b010,
        PH_READ = 3'b110
    } fpe_phase_type;
endpackage

/* File: design/fpe_bus_cycle.sv */
/*
  One asynchronous flash bus cycle, write or read, driven from registers.
  Assumes the caller waits for done before the next start; dq_in is a raw pin.
*/
module fpe_bus_cycle (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic we,
    input wire logic [fpe_pkg::ADDR_W-1:0] addr,
    input wire logic [fpe_pkg::DATA_W-1:0] wdata,
    output logic done,
    output logic [fpe_pkg::DATA_W-1:0] rdata,
    output logic [fpe_pkg::ADDR_W-1:0] pin_addr,
    output logic [fpe_pkg::DATA_W-1:0] pin_dq_out,
    output logic pin_dq_oe_n,
    input wire logic [fpe_pkg::DATA_W-1:0] pin_dq_in,
    output logic pin_ce_n,
    output logic pin_we_n,
    output logic pin_oe_n
);
    import fpe_pkg::*;

    fpe_phase_type ph_q;
    logic [7:0] cnt_q;
    logic [DATA_W-1:0] dq_meta_q;
    logic [DATA_W-1:0] dq_sync_q;

    // ========================================
    // Data pin synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta_q <= 16'h0000;
            dq_sync_q <= 16'h0000;
        end else begin
            dq_meta_q <= pin_dq_in;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ========================================
    // Cycle sequencer
    // Read strobe is held two extra cycles to cover the synchroniser delay
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= PH_IDLE;
            cnt_q <= 8'h00;
            done <= 1'b0;
            rdata <= 16'h0000;
            pin_addr <= 20'h00000;
            pin_dq_out <= 16'h0000;
            pin_dq_oe_n <= 1'b1;
            pin_ce_n <= 1'b1;
            pin_we_n <= 1'b1;
            pin_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (ph_q)
                PH_IDLE: if (start) begin
                    pin_addr <= addr;
                    pin_ce_n <= 1'b0;
                    cnt_q <= 8'h00;
                    if (we) begin
                        pin_dq_out <= wdata;
                        pin_dq_oe_n <= 1'b0;
                        ph_q <= PH_SETUP;
                    end else begin
                        pin_oe_n <= 1'b0;
                        ph_q <= PH_READ;
                    end
                end
                PH_SETUP: begin
                    pin_we_n <= 1'b0;
                    ph_q <= PH_PULSE;
                end
                PH_PULSE: if (cnt_q == 8'(WP_CYC - 1)) begin
                    pin_we_n <= 1'b1;
                    ph_q <= PH_HOLD;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
                PH_HOLD: begin
                    pin_ce_n <= 1'b1;
                    pin_dq_oe_n <= 1'b1;
                    done <= 1'b1;
                    ph_q <= PH_IDLE;
                end
                PH_READ: if (cnt_q == 8'(ACC_CYC + 2)) begin
                    rdata <= dq_sync_q;
                    pin_oe_n <= 1'b1;
                    pin_ce_n <= 1'b1;
                    done <= 1'b1;
                    ph_q <= PH_IDLE;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            endcase
        end
    end

    // ========================================
    // Checks
    AST_NO_CONTENTION: assert property (@(posedge clock) disable iff (!rst_n)
        !(!pin_we_n && !pin_oe_n))
        else $error("write and output strobes both active");
    AST_DRIVE_ON_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(pin_we_n) |-> !pin_dq_oe_n && !pin_ce_n ##1 !pin_dq_oe_n)
        else $error("data not driven around write strobe");
endmodule

/* File: design/fpe_host_ctrl.sv */
/*
  Host-side sequencer that turns single user commands into flash bus cycles.
  Assumes a word-mode flash on the pins and one command at a time on cmd_*.
*/
// Function
// - Unlock cycles use low address, zero upper data
// - Sector address placed on bits 19 to 12
// - Reset leaves id/query, and after limit flag
// - Bypass program only after bypass entry
// - Program is four cycles then polled to end
// - Bypass entry: two unlocks then 0x20
// - Bypass program: 0xA0 then address and data
// - Chip erase is six cycles
// - Added sectors only inside 50 us window
module fpe_host_ctrl (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire fpe_pkg::fpe_op_type cmd_op,
    input wire logic [fpe_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [fpe_pkg::DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    output logic resp_valid,
    output logic resp_err,
    output logic [fpe_pkg::DATA_W-1:0] resp_data,
    output logic [fpe_pkg::ADDR_W-1:0] flash_addr,
    output logic [fpe_pkg::DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [fpe_pkg::DATA_W-1:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic flash_rst_n
);
    import fpe_pkg::*;

    fpe_state_type state_q;
    fpe_mode_type mode_q;
    fpe_mode_type base_q;
    fpe_op_type op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [2:0] idx_q;
    logic retry_q;
    logic fail_q;
    logic [15:0] win_cnt_q;
    logic [7:0] hwr_cnt_q;
    logic bus_start;
    logic bus_we;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata;
    logic bus_done;
    logic [DATA_W-1:0] bus_rdata;
    logic legal;
    logic [2:0] seq_len;
    logic [36:0] seq_word;

    // ========================================
    // Command table
    function automatic logic [36:0] cyc(input fpe_op_type op, input logic [2:0] i,
                                        input logic [19:0] a, input logic [15:0] d);
        logic [19:0] sa;
        sa = {a[19:12], 12'h000};
        cyc = {1'b1, A_ANY, D_RESET};
        unique case (op)
            OP_PROG: cyc = (i == 3'h3) ? {1'b1, a, d} :
                (i == 3'h2) ? {1'b1, A_UNLOCK1, D_PROG} :
                (i == 3'h1) ? {1'b1, A_UNLOCK2, D_UNLOCK2} : {1'b1, A_UNLOCK1, D_UNLOCK1};
            OP_BYP_PROG: cyc = (i == 3'h1) ? {1'b1, a, d} : {1'b1, A_ANY, D_PROG};
            OP_BYP_EXIT: cyc = (i == 3'h1) ? {1'b1, A_ANY, D_BYP_EXIT2} :
                {1'b1, A_ANY, D_BYP_EXIT1};
            OP_BYP_ENTER, OP_ID, OP_CHIP, OP_SECTOR: begin
                // Unlock pairs sit at steps 0,1 of each such sequence, and also at 3,4 for chip and sector erase
                if (i == 3'h0 || i == 3'h3) cyc = {1'b1, A_UNLOCK1, D_UNLOCK1};
                else if (i == 3'h1 || i == 3'h4) cyc = {1'b1, A_UNLOCK2, D_UNLOCK2};
                else if (op == OP_BYP_ENTER) cyc = {1'b1, A_UNLOCK1, D_BYP_ENTER};
                else if (op == OP_ID) cyc = {1'b1, A_UNLOCK1, D_ID};
                else if (i == 3'h2) cyc = {1'b1, A_UNLOCK1, D_ERASE_SETUP};
                else if (op == OP_CHIP) cyc = {1'b1, A_UNLOCK1, D_CHIP};
                else cyc = {1'b1, sa, D_SECTOR};
            end
            OP_SECT_ADD: cyc = {1'b1, sa, D_SECTOR};
            OP_SUSPEND: cyc = {1'b1, A_ANY, D_SUSPEND};
            OP_RESUME: cyc = {1'b1, A_ANY, D_RESUME};
            OP_QUERY: cyc = {1'b1, A_QUERY, D_QUERY};
            OP_READ: cyc = {1'b0, a, 16'h0000};
            default: cyc = {1'b1, A_ANY, D_RESET};
        endcase
    endfunction

    always_comb begin
        unique case (op_q)
            OP_PROG: seq_len = 3'h4;
            OP_BYP_ENTER, OP_ID: seq_len = 3'h3;
            OP_BYP_PROG, OP_BYP_EXIT: seq_len = 3'h2;
            OP_CHIP, OP_SECTOR: seq_len = 3'h6;
            default: seq_len = 3'h1;
        endcase
    end

    // ========================================
    // Legality against the tracked device mode
    always_comb begin
        unique case (cmd_op)
            OP_PROG, OP_ID: legal = mode_q == MD_READ || mode_q == MD_SUSP;
            OP_BYP_ENTER, OP_CHIP, OP_SECTOR: legal = mode_q == MD_READ;
            OP_BYP_PROG, OP_BYP_EXIT: legal = mode_q == MD_BYPASS;
            OP_SECT_ADD: legal = mode_q == MD_WINDOW
                && win_cnt_q < 16'(WIN_CYC - WIN_GUARD_CYC);
            OP_SUSPEND: legal = mode_q == MD_WINDOW || mode_q == MD_ERASING;
            OP_RESUME: legal = mode_q == MD_SUSP;
            OP_RESET: legal = mode_q == MD_READ || mode_q == MD_ID
                || mode_q == MD_QUERY || mode_q == MD_WINDOW;
            OP_QUERY: legal = mode_q == MD_READ || mode_q == MD_ID;
            OP_READ: legal = mode_q != MD_ERASING;
            OP_WAIT: legal = mode_q == MD_ERASING;
            default: legal = 1'b1;
        endcase
    end

    assign seq_word = cyc(op_q, idx_q, addr_q, data_q);
    assign bus_start = state_q == ST_SEQ || state_q == ST_POLL;
    assign bus_we = state_q == ST_SEQ && seq_word[36];
    assign bus_addr = state_q == ST_POLL ? addr_q : seq_word[35:16];
    assign bus_wdata = seq_word[15:0];

    // ========================================
    // Sequencer; the single command port is what keeps sequences whole
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            op_q <= OP_READ;
            addr_q <= 20'h00000;
            data_q <= 16'h0000;
            idx_q <= 3'h0;
            retry_q <= 1'b0;
            fail_q <= 1'b0;
            cmd_ready <= 1'b1;
            resp_valid <= 1'b0;
            resp_err <= 1'b0;
            resp_data <= 16'h0000;
            hwr_cnt_q <= 8'h00;
            flash_rst_n <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            flash_rst_n <= 1'b1;
            unique case (state_q)
                ST_IDLE: if (cmd_valid) begin
                    cmd_ready <= 1'b0;
                    op_q <= cmd_op;
                    addr_q <= cmd_addr;
                    data_q <= cmd_data;
                    idx_q <= 3'h0;
                    retry_q <= 1'b0;
                    fail_q <= 1'b0;
                    resp_err <= !legal;
                    hwr_cnt_q <= 8'h00;
                    if (!legal) state_q <= ST_RESP;
                    else if (cmd_op == OP_HWRESET) state_q <= ST_HWR;
                    else if (cmd_op == OP_WAIT) state_q <= ST_POLL;
                    else state_q <= ST_SEQ;
                end
                ST_SEQ: state_q <= ST_WAIT;
                ST_WAIT: if (bus_done) begin
                    if (!seq_word[36]) resp_data <= bus_rdata;
                    if (idx_q == seq_len - 3'h1) begin
                        if (op_q == OP_PROG || op_q == OP_BYP_PROG || op_q == OP_CHIP)
                            state_q <= ST_POLL;
                        else state_q <= ST_RESP;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        state_q <= ST_SEQ;
                    end
                end
                ST_POLL: state_q <= ST_PWAIT;
                ST_PWAIT: if (bus_done) begin
                    resp_data <= bus_rdata;
                    // Erase reads back ones when done; program reads back its own data
                    if (bus_rdata[POLL_BIT] == ((op_q == OP_PROG || op_q == OP_BYP_PROG)
                            ? data_q[POLL_BIT] : 1'b1)) state_q <= ST_RESP;
                    else if (bus_rdata[LIMIT_BIT] && retry_q) state_q <= ST_FAIL;
                    else begin
                        retry_q <= retry_q | bus_rdata[LIMIT_BIT];
                        state_q <= ST_POLL;
                    end
                end
                ST_FAIL: begin
                    op_q <= OP_RESET;
                    idx_q <= 3'h0;
                    fail_q <= 1'b1;
                    resp_err <= 1'b1;
                    state_q <= ST_SEQ;
                end
                ST_HWR: begin
                    flash_rst_n <= 1'b0;
                    hwr_cnt_q <= hwr_cnt_q + 8'h01;
                    if (hwr_cnt_q == 8'(RP_CYC - 1)) state_q <= ST_RESP;
                end
                ST_RESP: begin
                    resp_valid <= 1'b1;
                    cmd_ready <= 1'b1;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Device mode tracking and erase window timer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MD_READ;
            base_q <= MD_READ;
            win_cnt_q <= 16'h0000;
        end else if (state_q == ST_RESP && (!resp_err || fail_q)) begin
            win_cnt_q <= 16'h0000;
            unique case (op_q)
                OP_BYP_ENTER: mode_q <= MD_BYPASS;
                OP_BYP_EXIT, OP_CHIP, OP_WAIT, OP_HWRESET: mode_q <= MD_READ;
                OP_SECTOR, OP_SECT_ADD: mode_q <= MD_WINDOW;
                OP_SUSPEND: mode_q <= MD_SUSP;
                OP_RESUME: mode_q <= MD_ERASING;
                OP_RESET: mode_q <= (mode_q == MD_ID && !fail_q) ? base_q : MD_READ;
                OP_QUERY: mode_q <= MD_QUERY;
                OP_ID: begin
                    base_q <= mode_q;
                    mode_q <= MD_ID;
                end
                default: mode_q <= mode_q;
            endcase
        end else if (mode_q == MD_WINDOW) begin
            win_cnt_q <= win_cnt_q + 16'h0001;
            if (win_cnt_q == 16'(WIN_CYC - 1)) mode_q <= MD_ERASING;
        end
    end

    fpe_bus_cycle u_bus (
        .clock(clock),
        .rst_n(rst_n),
        .start(bus_start),
        .we(bus_we),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .pin_addr(flash_addr),
        .pin_dq_out(flash_dq_out),
        .pin_dq_oe_n(flash_dq_oe_n),
        .pin_dq_in(flash_dq_in),
        .pin_ce_n(flash_ce_n),
        .pin_we_n(flash_we_n),
        .pin_oe_n(flash_oe_n)
    );

    // ========================================
    // Checks
    AST_BYPASS_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == ST_IDLE && cmd_valid && cmd_op == OP_BYP_PROG && mode_q != MD_BYPASS
        |=> state_q == ST_RESP && resp_err ##1 resp_valid && resp_err)
        else $error("bypass program sent outside bypass mode");
    AST_RESUME_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == ST_IDLE && cmd_valid && cmd_op == OP_RESUME && mode_q != MD_SUSP
        |=> resp_err && state_q == ST_RESP)
        else $error("resume sent while not suspended");
    AST_QUERY_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == ST_IDLE && cmd_valid && cmd_op == OP_QUERY
        && !(mode_q == MD_READ || mode_q == MD_ID) |=> resp_err)
        else $error("query sent from wrong mode");
    AST_WINDOW_ADD: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == ST_IDLE && cmd_valid && cmd_op == OP_SECT_ADD
        && win_cnt_q >= 16'(WIN_CYC - WIN_GUARD_CYC) |=> resp_err)
        else $error("sector added too late in the window");
    AST_CMD_UPPER: assert property (@(posedge clock) disable iff (!rst_n)
        bus_start && bus_we && !((op_q == OP_PROG && idx_q == 3'h3)
        || (op_q == OP_BYP_PROG && idx_q == 3'h1)) |-> bus_wdata[15:8] == 8'h00)
        else $error("command cycle with nonzero upper data");
    AST_SECTOR_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        bus_start && bus_we && bus_wdata == D_SECTOR && op_q != OP_RESUME
        |-> bus_addr[11:0] == 12'h000 && bus_addr[19:12] == addr_q[19:12])
        else $error("sector cycle address misplaced");
    AST_WINDOW_EXPIRE: assert property (@(posedge clock) disable iff (!rst_n)
        mode_q == MD_WINDOW && win_cnt_q == 16'(WIN_CYC - 1) && state_q != ST_RESP
        |=> mode_q == MD_ERASING)
        else $error("window expiry missed");
    AST_NO_RESET_IN_PROG: assert property (@(posedge clock) disable iff (!rst_n)
        bus_start && bus_we && bus_wdata == D_RESET |-> op_q == OP_RESET)
        else $error("reset written during a running operation");

    COV_PROG_DONE: cover property (@(posedge clock) disable iff (!rst_n)
        resp_valid && !resp_err && op_q == OP_PROG);
    COV_SECT_ADD: cover property (@(posedge clock) disable iff (!rst_n)
        resp_valid && !resp_err && op_q == OP_SECT_ADD);
    COV_SUSPEND: cover property (@(posedge clock) disable iff (!rst_n)
        resp_valid && !resp_err && op_q == OP_SUSPEND);
    COV_FAIL: cover property (@(posedge clock) disable iff (!rst_n) state_q == ST_FAIL);
endmodule

/* File: test/fpe_flash_model.sv */
/*
  Behavioural word-mode flash on the host pins; keeps 256 words.
  Assumes the bench resolves the shared data pin from the host data enable alone.
*/
module fpe_flash_model (
    input wire logic [19:0] addr,
    input wire logic [15:0] dq,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic rst_n,
    output logic [15:0] dq_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Command decode
    logic [15:0] mem [256];
    logic [15:0] pd;
    logic [3:0] st;
    logic byp, susp, lim;
    realtime t, tp, tw, te, tr;
    wire [7:0] c = dq[7:0];
    wire u1 = addr[10:0] == 11'h555;
    wire u2 = addr[10:0] == 11'h2AA;
    initial mem = '{default: 16'hFFFF};
    initial dq_drv = '0;
    always @(posedge we_n or negedge rst_n) begin
        t = $realtime;
        if (!rst_n) begin
            {st, byp, susp, lim} = '0;
            tp = 0;
            te = 0;
        end else if (!ce_n && lim) begin
            // A halted program keeps showing status until the reset command or a hardware reset
            if (c == 8'hF0) begin
                lim = 0;
                st = 0;
                tp = 0;
            end
        end else if (!ce_n && t >= tp) begin
            if (t < te) begin
                if (c == 8'hB0) begin
                    susp = 1;
                    tr = te - t;
                    te = 0;
                end else if (t < tw && c == 8'h30) begin
                    tw = t + 50us;
                    te = tw + 20us;
                end
            end else if (st == 9) begin
                lim = |(dq & ~mem[addr[7:0]]);
                mem[addr[7:0]] &= dq;
                pd = dq;
                tp = t + 2us;
                st = byp ? 8 : 0;
            end else if (st == 0 && susp && c == 8'h30) begin
                susp = 0;
                te = t + tr;
            end else if ((st == 0 || st == 3) && u1 && c == 8'hAA)
                st = st + 1;
            else if ((st == 1 || st == 4) && u2 && c == 8'h55)
                st = st + 1;
            else if ((st == 2 || st == 8) && c == 8'hA0)
                st = 9;
            else if (st == 2 && c == 8'h20) begin
                byp = 1;
                st = 8;
            end else if (st == 2 && c == 8'h80 && !susp)
                st = 3;
            else if (st == 5 && (c == 8'h10 || c == 8'h30)) begin
                mem = '{default: 16'hFFFF};
                tw = c == 8'h30 ? t + 50us : 0;
                te = (c == 8'h30 ? tw : t) + 20us;
                st = 0;
            end else if (st == 2 && c == 8'h90)
                st = 6;
            else if (st == 8 && c == 8'h90)
                st = 10;
            else if (st == 10 && c == 8'h00)
                {st, byp} = '0;
            else if ((st == 0 || st == 6) && c == 8'h98)
                st = 11;
            else if (st == 6 || st == 11)
                st = c == 8'hF0 ? 0 : st;
            else
                st = byp ? 8 : 0;
        end
    end
    // Released pin shows the inverse so a stale value never passes
    always @(oe_n or ce_n) begin
        #1;
        if (!oe_n && !ce_n)
            dq_drv = ($realtime < tp || lim) ? {8'h00, ~pd[7], 1'b0, lim, 5'h00} :
                $realtime < te ? '0 : mem[addr[7:0]];
        else
            dq_drv = ~dq_drv;
    end
endmodule

/* File: test/fpe_host_ctrl_tb.sv */
/*
  Self-checking bench for the flash host sequencer against a flash model.
  Assumes the package constants and the command port hand-over timing.
*/
module fpe_host_ctrl_tb;
    import fpe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    // ====================
    // Signals
    logic clock = 0, rst_n = 0, cmd_valid = 0, cmd_ready, resp_valid, resp_err;
    logic oe, ce, we, oen, frst;
    fpe_op_type cmd_op = OP_READ;
    logic [19:0] cmd_addr = '0, fa, a;
    logic [15:0] cmd_data = '0, resp_data, fdo, pin, mdq, d;
    logic [15:0] shad [256];
    fpe_op_type bad [6] = '{OP_BYP_PROG, OP_BYP_EXIT, OP_SECT_ADD, OP_SUSPEND, OP_RESUME, OP_WAIT};
    int seed = 32'h2674, errors = 0, compares = 0, cyc = 0;
    always #20 clock = ~clock;
    assign pin = oe ? mdq : fdo;
    fpe_host_ctrl dut_u (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data),
        .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe_n(oe), .flash_dq_in(pin),
        .flash_ce_n(ce), .flash_we_n(we), .flash_oe_n(oen), .flash_rst_n(frst));
    fpe_flash_model mdl_u (.addr(fa), .dq(pin), .ce_n(ce), .we_n(we), .oe_n(oen),
        .rst_n(frst), .dq_drv(mdq));
    // ====================
    // Tasks
    function automatic logic [15:0] progd(input logic [15:0] old, input logic [15:0] nw);
        return old & nw;
    endfunction
    task automatic cmd(input fpe_op_type op, input logic [19:0] ad, input logic err);
        @(negedge clock);
        cmd_valid = 1;
        cmd_op = op;
        cmd_addr = ad;
        @(negedge clock);
        cmd_valid = 0;
        while (resp_valid !== 1'b1) @(negedge clock);
        `CHK("resp_err", err, resp_err)
        `CHK("cmd_ready", 1'b1, cmd_ready)
    endtask
    task automatic rd(input logic [19:0] ad);
        cmd(OP_READ, ad, 1'b0);
        `CHK("read data", shad[ad[7:0]], resp_data)
    endtask
    // Same address again shows that bits only clear
    task automatic prog(input fpe_op_type op, input bit same);
        if (!same) begin
            a = $random(seed);
            while (shad[a[7:0]] !== 16'hFFFF) a = $random(seed);
        end
        d = $random(seed);
        cmd_data = d;
        cmd(op, a, |(d & ~shad[a[7:0]]));
        shad[a[7:0]] = progd(shad[a[7:0]], d);
        rd(a);
    endtask
    task automatic finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            finish_test();
        end
    end
    // ====================
    // Scenarios
    initial begin
        shad = '{default: 16'hFFFF};
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1;
        foreach (bad[i]) cmd(bad[i], 20'h00000, 1'b1);
        repeat (4) prog(OP_PROG, 0);
        prog(OP_PROG, 1);
        $display("test program finished");
        cmd(OP_BYP_ENTER, 20'h00000, 1'b0);
        repeat (3) prog(OP_BYP_PROG, 0);
        cmd(OP_PROG, 20'h00000, 1'b1);
        cmd(OP_QUERY, 20'h00000, 1'b1);
        cmd(OP_BYP_EXIT, 20'h00000, 1'b0);
        prog(OP_PROG, 1);
        $display("test bypass finished");
        cmd(OP_ID, 20'h00000, 1'b0);
        cmd(OP_RESET, 20'h00000, 1'b0);
        rd(a);
        cmd(OP_ID, 20'h00000, 1'b0);
        cmd(OP_PROG, 20'h00000, 1'b1);
        cmd(OP_QUERY, 20'h00000, 1'b0);
        cmd(OP_RESET, 20'h00000, 1'b0);
        prog(OP_PROG, 0);
        $display("test id finished");
        cmd(OP_CHIP, 20'h00000, 1'b0);
        shad = '{default: 16'hFFFF};
        rd(a);
        $display("test chip finished");
        cmd(OP_SECTOR, 20'h00000, 1'b0);
        cmd(OP_SECT_ADD, 20'h01000, 1'b0);
        cmd(OP_WAIT, 20'h00000, 1'b1);
        repeat (WIN_CYC + 50) @(negedge clock);
        cmd(OP_SECT_ADD, 20'h02000, 1'b1);
        cmd(OP_SUSPEND, 20'h00000, 1'b0);
        prog(OP_PROG, 0);
        cmd(OP_RESUME, 20'h00000, 1'b0);
        cmd(OP_WAIT, 20'h00000, 1'b0);
        rd(a);
        $display("test sector finished");
        cmd(OP_HWRESET, 20'h00000, 1'b0);
        prog(OP_PROG, 0);
        $display("test reset finished");
        finish_test();
    end
endmodule
